// ### verilog/ctsup_top.v
// CT circuit supervision: limit checks, blocking, alarm delay, Avalon-MM registers
// Assumes magnitudes and phasors come from same-clock measurement logic with a refresh strobe
// Contract
// R1 - Comparisons release only past 97 % or 103 % of their threshold.
// R2 - One threshold for all currents; any one current exceeding it picks up (lower limit: code also needs one phase not above it).
// R3 - Any phase above the upper limit means primary fault; supervision stays inactive.
// R4 - Activation needs the lower phase limit condition on the phase currents.
// R5 - Activation needs min/max phase ratio below its setting, default 10.00 %.
// R6 - Activation needs negative/positive sequence ratio above its setting, default 49.00 %.
// R7 - With residual enabled, summed minus measured residual must exceed its limit.
// R8 - Alarm asserts after the settable delay, default 0.5 s, 5 ms steps.
// R9 - Blocking input is sampled at the start of every evaluation cycle.
// R10 - Pick-up while unblocked asserts start and begins delay timing.
// R11 - Pick-up while blocked asserts blocked and stops further processing.
// R12 - Blocking after start clears start and resets timing like a drop-out.
// R13 - Blocking source asserts at least 5 ms before the delay expires.
// R14 - Only definite, fixed delay; no inverse-time curves.
// R15 - Read-only residual magnitude and angle difference diagnostics.
// R16 - Read-only natural unbalance angle after compensation, 0.01 degree steps.
// R17 - Setting-group switch takes effect while running, without stopping.
// R18 - Alarm only when all enabled conditions hold for the whole delay.
// R19 - Residual selector: none, channel one or channel two; none disables it.
// R20 - Polarity setting adds or subtracts the residual channel.
// R21 - Measurements refresh every 5 ms and supervision evaluates each refresh.
// R22 - Any condition dropping before expiry clears the timer, no alarm.
// R23 - General reset clears timer and start, blocked and alarm outputs.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ctsup_defs.vh"

module ctsup_top (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        gen_reset_in,
	// Measurement refresh and magnitudes (0.01 x In)
	input  wire        meas_valid_in,
	input  wire [15:0] phase_a_fundamental_in,
	input  wire [15:0] phase_b_fundamental_in,
	input  wire [15:0] phase_c_fundamental_in,
	input  wire [15:0] pos_seq_in,
	input  wire [15:0] neg_seq_in,
	// Phasors: phase sum and residual channels, signed 0.01 x In
	input  wire [15:0] sum_re_in,
	input  wire [15:0] sum_im_in,
	input  wire [15:0] residual_channel_one_re_in,
	input  wire [15:0] residual_channel_one_im_in,
	input  wire [15:0] residual_channel_two_re_in,
	input  wire [15:0] residual_channel_two_im_in,
	// Angles, signed 0.01 degree
	input  wire [15:0] sum_ang_in,
	input  wire [15:0] res_ang_in,
	// Blocking matrix
	input  wire        block_in,
	// Function outputs
	output reg         start_out,
	output reg         blocked_out,
	output wire        alarm_out,
	// Avalon-MM slave
	input  wire [7:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output wire        avs_waitrequest_out
);
	// Byte-lane merge of a write into an old value
	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction

	// Absolute value of a signed 17-bit quantity
	function [16:0] abs17;
		input [16:0] v;
		begin
			abs17 = v[16] ? (17'h00000 - v) : v;
		end
	endfunction

	// Reset value of a setting slot
	function [19:0] def_val;
		input [2:0] s;
		begin
			case (s)
				`CTSUP_S_HIGH: def_val = `CTSUP_HIGH_DEF;
				`CTSUP_S_LOW:  def_val = `CTSUP_LOW_DEF;
				`CTSUP_S_MMR:  def_val = `CTSUP_MMR_DEF;
				`CTSUP_S_NPR:  def_val = `CTSUP_NPR_DEF;
				`CTSUP_S_SUMD: def_val = `CTSUP_SUMD_DEF;
				default:       def_val = `CTSUP_DLY_DEF;
			endcase
		end
	endfunction

	// Registers
	reg  [19:0] set_r [0:11];
	reg         grp_r;
	reg  [1:0]  rsel_r;
	reg         pol_r;
	reg  [16:0] off_re_r;
	reg  [16:0] off_im_r;
	reg  [16:0] nat_ang_r;
	reg  [16:0] dmag_r;
	reg  [16:0] dang_r;
	reg         blk_smp_r;
	reg         eval_d_r;
	reg         ack_r;
	integer     k;

	wire        req;
	wire        do_wr;
	wire        set_hit;
	wire [3:0]  set_idx;
	wire [19:0] cnt;
	wire        done;
	wire [31:0] wr_merge;

	// Active settings follow the selected group at every evaluation
	wire [3:0]  gb;
	assign gb = grp_r ? 4'h6 : 4'h0; // [R17]
	wire [19:0] s_high;
	wire [19:0] s_low;
	wire [19:0] s_mmr;
	wire [19:0] s_npr;
	wire [19:0] s_sumd;
	wire [19:0] s_dly;
	assign s_high = set_r[gb + 4'h0];
	assign s_low  = set_r[gb + 4'h1];
	assign s_mmr  = set_r[gb + 4'h2];
	assign s_npr  = set_r[gb + 4'h3];
	assign s_sumd = set_r[gb + 4'h4];
	assign s_dly  = set_r[gb + 4'h5];

	// Min and max of the phase magnitudes
	wire [15:0] ia;
	wire [15:0] ib;
	wire [15:0] ic;
	wire [15:0] mx_ab;
	wire [15:0] mn_ab;
	wire [15:0] i_max;
	wire [15:0] i_min;
	assign ia    = phase_a_fundamental_in;
	assign ib    = phase_b_fundamental_in;
	assign ic    = phase_c_fundamental_in;
	assign mx_ab = (ia > ib) ? ia : ib;
	assign mn_ab = (ia < ib) ? ia : ib;
	assign i_max = (mx_ab > ic) ? mx_ab : ic;
	assign i_min = (mn_ab < ic) ? mn_ab : ic;

	// Residual channel selection and polarity
	wire        res_en;
	wire [15:0] r_re;
	wire [15:0] r_im;
	wire [16:0] raw_re;
	wire [16:0] raw_im;
	wire [16:0] d_re;
	wire [16:0] d_im;
	wire [16:0] a_re;
	wire [16:0] a_im;
	wire [16:0] d_big;
	wire [16:0] d_sml;
	assign res_en = (rsel_r == `CTSUP_RSEL_ONE) || (rsel_r == `CTSUP_RSEL_TWO); // [R19]
	assign r_re = (rsel_r == `CTSUP_RSEL_TWO) ? residual_channel_two_re_in
	                                          : residual_channel_one_re_in; // [R19]
	assign r_im = (rsel_r == `CTSUP_RSEL_TWO) ? residual_channel_two_im_in
	                                          : residual_channel_one_im_in;
	assign raw_re = pol_r ? ({sum_re_in[15], sum_re_in} - {r_re[15], r_re})
	                      : ({sum_re_in[15], sum_re_in} + {r_re[15], r_re}); // [R20]
	assign raw_im = pol_r ? ({sum_im_in[15], sum_im_in} - {r_im[15], r_im})
	                      : ({sum_im_in[15], sum_im_in} + {r_im[15], r_im}); // [R20]
	// Natural unbalance removed by the captured offset
	assign d_re  = raw_re - off_re_r;
	assign d_im  = raw_im - off_im_r;
	assign a_re  = abs17(d_re);
	assign a_im  = abs17(d_im);
	assign d_big = (a_re > a_im) ? a_re : a_im;
	assign d_sml = (a_re > a_im) ? a_im : a_re;

	// Angle difference between summed phases and residual
	wire [16:0] ang_diff;
	assign ang_diff = {sum_ang_in[15], sum_ang_in} - {res_ang_in[15], res_ang_in};

	// Hysteresis comparators, all updated on the refresh strobe
	wire [2:0] hi_act;
	wire [2:0] lo_act;
	wire       mmr_act;
	wire       npr_act;
	wire       sum_act;
	wire [15:0] ph [0:2];
	assign ph[0] = ia;
	assign ph[1] = ib;
	assign ph[2] = ic;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ph
			// Phase above upper limit
			ctsup_hyst u_hi (
				.clk_in   (clk_in),
				.rst_in   (rst_in),
				.clr_in   (1'b0),
				.eval_in  (meas_valid_in), // [R21]
				.under_in (1'b0),
				.meas_in  ({16'h0000, ph[g]}),
				.thr_in   ({12'h000, s_high}),
				.act_out  (hi_act[g])
			);
			// Phase above lower limit
			ctsup_hyst u_lo (
				.clk_in   (clk_in),
				.rst_in   (rst_in),
				.clr_in   (1'b0),
				.eval_in  (meas_valid_in),
				.under_in (1'b0),
				.meas_in  ({16'h0000, ph[g]}),
				.thr_in   ({12'h000, s_low}),
				.act_out  (lo_act[g])
			);
		end
	endgenerate

	// Min/max ratio below setting: min*10000 < ratio*max
	ctsup_hyst u_mmr (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clr_in   (1'b0),
		.eval_in  (meas_valid_in),
		.under_in (1'b1),
		.meas_in  ({16'h0000, i_min} * `CTSUP_RATIO_SCALE), // [R5]
		.thr_in   ({16'h0000, i_max} * {12'h000, s_mmr}),
		.act_out  (mmr_act)
	);

	// Negative/positive sequence ratio above setting
	ctsup_hyst u_npr (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clr_in   (1'b0),
		.eval_in  (meas_valid_in),
		.under_in (1'b0),
		.meas_in  ({16'h0000, neg_seq_in} * `CTSUP_RATIO_SCALE), // [R6]
		.thr_in   ({16'h0000, pos_seq_in} * {12'h000, s_npr}),
		.act_out  (npr_act)
	);

	// Residual difference above limit, held clear while disabled
	ctsup_hyst u_sum (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clr_in   (~res_en),
		.eval_in  (meas_valid_in),
		.under_in (1'b0),
		.meas_in  ({15'h0000, d_big + {1'b0, d_sml[16:1]}}), // [R7]
		.thr_in   ({12'h000, s_sumd}),
		.act_out  (sum_act)
	);

	// All enabled conditions together form pick-up
	wire fault_hi;
	wire low_ok;
	wire pickup;
	assign fault_hi = |hi_act; // [R3]
	assign low_ok   = (|lo_act) && !(&lo_act); // [R4] [R2]
	assign pickup   = !fault_hi && low_ok && mmr_act && npr_act &&
	                  (sum_act || !res_en); // [R18] [R7]

	// Blocking sampled with each refresh, used one cycle later
	always @(posedge clk_in) begin
		if (rst_in) begin
			blk_smp_r <= 1'b0;
			eval_d_r  <= 1'b0;
		end else begin
			eval_d_r <= meas_valid_in;
			if (meas_valid_in)
				blk_smp_r <= block_in; // [R9]
		end
	end

	// Start and blocked decided after comparators settle
	always @(posedge clk_in) begin
		if (rst_in || gen_reset_in) begin
			start_out   <= 1'b0; // [R23]
			blocked_out <= 1'b0;
		end else if (eval_d_r) begin
			start_out   <= pickup && !blk_smp_r; // [R10] [R12]
			blocked_out <= pickup && blk_smp_r; // [R11]
		end
	end

	// Alarm delay runs only while start holds
	ctsup_dly u_dly (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clr_in   (gen_reset_in), // [R23]
		.tick_in  (eval_d_r),
		.run_in   (pickup && !blk_smp_r), // [R10] [R22]
		.dly_in   (s_dly),
		.cnt_out  (cnt),
		.done_out (done)
	);
	assign alarm_out = done; // [R8]

	// Bus handshake: one wait state per access
	assign req     = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !ack_r;
	assign do_wr   = avs_write_in && ack_r;
	assign set_hit = (avs_address_in[7:5] == 3'h1 || avs_address_in[7:5] == 3'h2) &&
	                 (avs_address_in[4:2] < 3'h6) && (avs_address_in[1:0] == 2'h0);
	assign set_idx = (avs_address_in[7:5] == 3'h2 ? 4'h6 : 4'h0) + {1'b0, avs_address_in[4:2]};
	// Setting write merged by byte lanes; only the low 20 bits are stored
	assign wr_merge = be_merge({12'h000, set_r[set_idx]}, avs_writedata_in,
	                           avs_byteenable_in);

	// Configuration writes and diagnostics capture
	always @(posedge clk_in) begin
		if (rst_in) begin
			ack_r     <= 1'b0;
			grp_r     <= 1'b0;
			rsel_r    <= `CTSUP_RSEL_NONE;
			pol_r     <= 1'b0;
			off_re_r  <= 17'h00000;
			off_im_r  <= 17'h00000;
			nat_ang_r <= 17'h00000;
			dmag_r    <= 17'h00000;
			dang_r    <= 17'h00000;
			for (k = 0; k < `CTSUP_NSLOT; k = k + 1) begin
				set_r[k]                <= def_val(k[2:0]);
				set_r[k + `CTSUP_NSLOT] <= def_val(k[2:0]);
			end
		end else begin
			ack_r <= req && !ack_r;
			if (meas_valid_in) begin
				dmag_r <= d_big + {1'b0, d_sml[16:1]}; // [R15]
				dang_r <= ang_diff - nat_ang_r; // [R15]
			end
			if (do_wr && avs_address_in == `CTSUP_CTRL_OFF && avs_byteenable_in[0]) begin
				grp_r  <= avs_writedata_in[`CTSUP_CTRL_GRP]; // [R17]
				rsel_r <= avs_writedata_in[`CTSUP_CTRL_RSEL_HI:`CTSUP_CTRL_RSEL_LO];
				pol_r  <= avs_writedata_in[`CTSUP_CTRL_POL];
				if (avs_writedata_in[`CTSUP_CTRL_COMP]) begin
					off_re_r  <= raw_re;
					off_im_r  <= raw_im;
					nat_ang_r <= ang_diff; // [R16]
				end
			end
			if (do_wr && set_hit)
				set_r[set_idx] <= wr_merge[19:0]; // [R17]
		end
	end

	// Read data loaded while waitrequest is high, stable when it drops
	always @(posedge clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (avs_read_in && !ack_r) begin
			if (set_hit)
				avs_readdata_out <= {12'h000, set_r[set_idx]};
			else begin
				case (avs_address_in)
					`CTSUP_CTRL_OFF: avs_readdata_out <= {28'h0000000, pol_r, rsel_r, grp_r};
					`CTSUP_STAT_OFF: avs_readdata_out <= {25'h0000000, blk_smp_r, res_en,
					                  fault_hi, pickup, done, blocked_out, start_out};
					`CTSUP_DMAG_OFF: avs_readdata_out <= {15'h0000, dmag_r}; // [R15]
					`CTSUP_DANG_OFF: avs_readdata_out <= {{15{dang_r[16]}}, dang_r};
					`CTSUP_NANG_OFF: avs_readdata_out <= {{15{nat_ang_r[16]}}, nat_ang_r};
					`CTSUP_TMR_OFF:  avs_readdata_out <= {12'h000, cnt};
					default:         avs_readdata_out <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // ctsup_top
`default_nettype wire

// ### verilog/ctsup_defs.vh
// CT circuit supervision: register map, field positions, reset values, timing
// Assumes byte addresses on an 8-bit Avalon-MM address, one 32-bit word per register
`ifndef CTSUP_DEFS_VH
`define CTSUP_DEFS_VH

// Register byte offsets
`define CTSUP_CTRL_OFF      8'h00
`define CTSUP_STAT_OFF      8'h04
`define CTSUP_DMAG_OFF      8'h08
`define CTSUP_DANG_OFF      8'h0C
`define CTSUP_NANG_OFF      8'h10
`define CTSUP_TMR_OFF       8'h14
`define CTSUP_GRP0_OFF      8'h20
`define CTSUP_GRP1_OFF      8'h40

// Control fields
`define CTSUP_CTRL_GRP      0
`define CTSUP_CTRL_RSEL_LO  1
`define CTSUP_CTRL_RSEL_HI  2
`define CTSUP_CTRL_POL      3
`define CTSUP_CTRL_COMP     4

// Residual selector codes
`define CTSUP_RSEL_NONE     2'h0
`define CTSUP_RSEL_ONE      2'h1
`define CTSUP_RSEL_TWO      2'h2

// Setting slot index within a group
`define CTSUP_S_HIGH        3'h0
`define CTSUP_S_LOW         3'h1
`define CTSUP_S_MMR         3'h2
`define CTSUP_S_NPR         3'h3
`define CTSUP_S_SUMD        3'h4
`define CTSUP_S_DLY         3'h5
`define CTSUP_NSLOT         6

// Setting reset values (0.01 x In, 0.01 %, delay in ticks)
`define CTSUP_HIGH_DEF      20'h00078
`define CTSUP_LOW_DEF       20'h0000A
`define CTSUP_MMR_DEF       20'h003E8
`define CTSUP_NPR_DEF       20'h01324
`define CTSUP_SUMD_DEF      20'h0000A

// Timing: evaluation tick period and default alarm delay in ms
`define CTSUP_TICK_MS       5
`define CTSUP_DLY_DEF_MS    500
`define CTSUP_DLY_DEF       20'h00064 // 500 ms in 5 ms ticks

// Hysteresis percentages and ratio scale
`define CTSUP_REL_OVER      40'd97
`define CTSUP_REL_UNDER     40'd103
`define CTSUP_PCT           40'd100
`define CTSUP_RATIO_SCALE   32'd10000

`endif

// ### verilog/ctsup_hyst.v
// Threshold comparator with built-in release hysteresis
// Assumes eval_in is a one-cycle strobe on the same clock as the inputs
`timescale 1ns/100ps
`default_nettype none
`include "ctsup_defs.vh"

module ctsup_hyst (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        clr_in,
	// Evaluation
	input  wire        eval_in,
	input  wire        under_in,
	input  wire [31:0] meas_in,
	input  wire [31:0] thr_in,
	// Result
	output reg         act_out
);
	wire [39:0] meas_w;
	wire [39:0] thr_w;
	assign meas_w = {8'h00, meas_in} * `CTSUP_PCT;
	assign thr_w  = {8'h00, thr_in};

	// Pick-up on crossing, release only past 97 % or 103 % of threshold
	always @(posedge clk_in) begin
		if (rst_in || clr_in) begin
			act_out <= 1'b0;
		end else if (eval_in) begin
			if (!under_in) begin
				if (meas_in > thr_in)
					act_out <= 1'b1; // [R1] [R2]
				else if (meas_w < thr_w * `CTSUP_REL_OVER)
					act_out <= 1'b0; // [R1]
			end else begin
				if (meas_in < thr_in)
					act_out <= 1'b1; // [R1]
				else if (meas_w > thr_w * `CTSUP_REL_UNDER)
					act_out <= 1'b0; // [R1]
			end
		end
	end
endmodule // ctsup_hyst
`default_nettype wire

// ### verilog/ctsup_dly.v
// Definite-time alarm delay counted in evaluation ticks
// Assumes tick_in is a one-cycle strobe, one per measurement refresh
`timescale 1ns/100ps
`default_nettype none

module ctsup_dly (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        clr_in,
	// Timing control
	input  wire        tick_in,
	input  wire        run_in,
	input  wire [19:0] dly_in,
	// Status
	output reg  [19:0] cnt_out,
	output reg         done_out
);
	// Fixed delay only; any drop of run restarts from zero
	always @(posedge clk_in) begin
		if (rst_in || clr_in) begin
			cnt_out  <= 20'h00000; // [R23]
			done_out <= 1'b0;
		end else if (tick_in) begin
			if (!run_in) begin
				cnt_out  <= 20'h00000; // [R22] [R12]
				done_out <= 1'b0;
			end else if (cnt_out >= dly_in) begin
				done_out <= 1'b1; // [R14]
			end else begin
				cnt_out <= cnt_out + 20'h00001; // [R8]
				if (cnt_out + 20'h00001 >= dly_in)
					done_out <= 1'b1; // [R18]
			end
		end
	end
endmodule // ctsup_dly
`default_nettype wire

// ### verification/ctsup_props.sv
// Checker for the CT supervision top: output timing against the refresh strobe
// Assumes one clock, sync active-high reset, strobes at least 3 cycles apart
`timescale 1ns/100ps
`default_nettype none

module ctsup_props (
	// Clock and resets
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic gen_reset_in,
	// Evaluation inputs
	input wire logic meas_valid_in,
	input wire logic block_in,
	// Function outputs
	input wire logic start_out,
	input wire logic blocked_out,
	input wire logic alarm_out
);
	// One domain: shared clock and reset
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Start and blocked rise only from an evaluation two edges back
	property p_start_src;
		$rose(start_out) |-> $past(meas_valid_in, 2) && !$past(block_in, 2);
	endproperty
	a_start_src: assert property (p_start_src) else $error("start rose unprompted");
	property p_blocked_src;
		$rose(blocked_out) |-> $past(meas_valid_in, 2) && $past(block_in, 2);
	endproperty
	a_blocked_src: assert property (p_blocked_src) else $error("blocked rose unprompted");
	property p_blocked_excl;
		blocked_out |-> !start_out && !alarm_out;
	endproperty
	a_blocked_excl: assert property (p_blocked_excl) else $error("blocked with start");

	// A blocked evaluation drops start and alarm
	property p_block_clears;
		$past(meas_valid_in, 2) && $past(block_in, 2) |-> !start_out && !alarm_out;
	endproperty
	a_block_clears: assert property (p_block_clears) else $error("start kept when blocked");

	// Outputs move only on an evaluation or a general reset
	property p_eval_only;
		!$past(meas_valid_in, 2) && !$past(gen_reset_in)
			|-> $stable({start_out, blocked_out, alarm_out});
	endproperty
	a_eval_only: assert property (p_eval_only) else $error("outputs moved off strobe");

	// Alarm only alongside start, rising on an unblocked evaluation
	property p_alarm_start;
		alarm_out |-> start_out;
	endproperty
	a_alarm_start: assert property (p_alarm_start) else $error("alarm without start");
	property p_alarm_rise;
		$rose(alarm_out) |-> $past(meas_valid_in, 2) && !$past(block_in, 2);
	endproperty
	a_alarm_rise: assert property (p_alarm_rise) else $error("alarm rose off strobe");

	// General reset clears all outputs at the next edge
	property p_gen_reset;
		gen_reset_in && !$past(meas_valid_in) |=> !start_out && !blocked_out && !alarm_out;
	endproperty
	a_gen_reset: assert property (p_gen_reset) else $error("general reset ignored");
endmodule // ctsup_props

bind ctsup_top ctsup_props u_ctsup_props (
	.clk_in(clk_in), .rst_in(rst_in), .gen_reset_in(gen_reset_in),
	.meas_valid_in(meas_valid_in), .block_in(block_in),
	.start_out(start_out), .blocked_out(blocked_out), .alarm_out(alarm_out)
);

`default_nettype wire

// ### verification/ctsup_meas_src.sv
// Measurement source: refresh strobe, magnitudes and blocking input
// Assumes the bench changes values between strobes; data is scrambled off-strobe
`timescale 1ns/100ps
`default_nettype none

module ctsup_meas_src #(
	parameter int PER = 8
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Values to present
	input  wire logic [79:0] mag_in,
	input  wire logic        blk_in,
	// To the supervision block
	output logic             valid_out,
	output logic      [79:0] mag_out,
	output logic             blk_out
);
	logic [3:0] cnt_r;

	// Refresh strobe once per shortened period, quiet in reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_r <= 4'h0;
			valid_out <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == 4'(PER - 1)) ? 4'h0 : cnt_r + 4'h1;
			valid_out <= (cnt_r == 4'(PER - 1));
		end
	end

	// Values good only on the strobe, inverted otherwise
	assign mag_out = valid_out ? mag_in : ~mag_in;
	assign blk_out = valid_out ? blk_in : ~blk_in;
endmodule // ctsup_meas_src

`default_nettype wire

// ### verification/ctsup_top_bench.sv
// Self-checking bench for the CT supervision top
// Assumes a 250 MHz clock, refresh shortened to 8 cycles, fixed seed
`timescale 1ns/100ps
`default_nettype none

module ctsup_top_bench;
	localparam logic [31:0] DEFS [6] = '{32'h78, 32'hA, 32'h3E8, 32'h1324, 32'hA, 32'h64};
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        gen_reset_in = 1'b0;
	logic        blk = 1'b0;
	logic [79:0] mg = 80'h0;
	logic [15:0] sa = 16'h0;
	logic [15:0] ra = 16'h0;
	logic [15:0] sr = 16'h0;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] q;
	logic [16:0] na;
	logic [31:0] xs = 32'hF54DEE1B;
	wire         vld;
	wire         blko;
	wire  [79:0] mgo;
	wire         st, bl, al, wt;
	wire  [31:0] rdat;
	int          n_mismatch = 0;
	int          compares = 0;

	// Clock and run limit
	initial forever #2 clk_in = ~clk_in;
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	ctsup_meas_src #(.PER(8)) u_ctsup_meas_src (
		.clk_in(clk_in), .rst_in(rst_in), .mag_in(mg), .blk_in(blk),
		.valid_out(vld), .mag_out(mgo), .blk_out(blko)
	);
	ctsup_top u_ctsup_top (
		.clk_in(clk_in), .rst_in(rst_in), .gen_reset_in(gen_reset_in),
		.meas_valid_in(vld), .block_in(blko),
		.phase_a_fundamental_in(mgo[15:0]), .phase_b_fundamental_in(mgo[31:16]),
		.phase_c_fundamental_in(mgo[47:32]), .pos_seq_in(mgo[63:48]), .neg_seq_in(mgo[79:64]),
		.sum_re_in(sr), .sum_im_in(16'h0000),
		.residual_channel_one_re_in(16'h0000 - sr), .residual_channel_one_im_in(16'h0000),
		.residual_channel_two_re_in(sr), .residual_channel_two_im_in(16'h0000),
		.sum_ang_in(sa), .res_ang_in(ra),
		.start_out(st), .blocked_out(bl), .alarm_out(al),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wt)
	);

	function automatic logic [31:0] rnd();
		xs = xs ^ (xs << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
		return xs;
	endfunction
	// Healthy: balanced phases {neg, pos, c, b, a}
	function automatic logic [79:0] ok_v(input logic [15:0] m);
		return {16'h0000, m, m, m, m};
	endfunction
	// Phase A lost: min/max zero, neg/pos above one half
	function automatic logic [79:0] brk_v(input logic [15:0] m);
		return {16'(m / 3 + 1), 16'(m * 2 / 3), m, m, 16'h0000};
	endfunction
	function automatic logic [15:0] rm();
		return 16'(30 + rnd() % 80);
	endfunction

	task automatic end_sim();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail();
		n_mismatch++;
		end_sim();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus cycle, held until waitrequest is seen low
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_in);
			k++;
		end while (wt !== 1'b0 && k < 50);
		if (k >= 50) fail();
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Present values, let one evaluation land, compare start, blocked, alarm
	task automatic step(input logic [79:0] m, input logic b, input logic [2:0] e);
		int k;
		k = 0;
		@(posedge clk_in);
		mg <= m;
		blk <= b;
		sa <= 16'(rnd());
		ra <= 16'(rnd());
		do begin
			@(negedge clk_in);
			k++;
		end while (vld !== 1'b1 && k < 20);
		if (k >= 20) fail();
		repeat (3) @(negedge clk_in);
		chk("flags", {29'h0, e}, {29'h0, st, bl, al});
	endtask

	// Main sequence
	initial begin
		sr <= 16'(50 + rnd() % 100);
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			av(1'b0, 8'(8'h20 + 4 * i), 32'h0);
			chk("setting", DEFS[i], q);
		end
		av(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h0, q);
		av(1'b1, 8'h34, 32'h3);
		av(1'b1, 8'h54, 32'h5);
		av(1'b0, 8'h34, 32'h0);
		chk("delay", 32'h3, q);
		$display("test registers done");
		step(ok_v(rm()), 1'b0, 3'b000);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b101);
		step(ok_v(rm()), 1'b0, 3'b000);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b1, 3'b010);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b101);
		step(ok_v(rm()), 1'b0, 3'b000);
		repeat (3) step(brk_v(rm()), 1'b1, 3'b010);
		$display("test delay and blocking done");
		step({16'd34, 16'd66, 16'd100, 16'd121, 16'd0}, 1'b0, 3'b000);
		step({16'd34, 16'd66, 16'd100, 16'd118, 16'd0}, 1'b0, 3'b000);
		step({16'd34, 16'd66, 16'd100, 16'd115, 16'd0}, 1'b0, 3'b100);
		step({16'd3, 16'd6, 16'd9, 16'd9, 16'd0}, 1'b0, 3'b000);
		step({16'd40, 16'd100, 16'd100, 16'd100, 16'd0}, 1'b0, 3'b000);
		step({16'd34, 16'd66, 16'd60, 16'd60, 16'd9}, 1'b0, 3'b000);
		$display("test limits done");
		av(1'b1, 8'h00, 32'h2);
		step(brk_v(rm()), 1'b0, 3'b000);
		av(1'b1, 8'h00, 32'hA);
		step(brk_v(rm()), 1'b0, 3'b100);
		av(1'b0, 8'h08, 32'h0);
		chk("diff", 32'(2 * sr), q);
		av(1'b1, 8'h00, 32'h1A);
		na = {sa[15], sa} - {ra[15], ra};
		av(1'b0, 8'h10, 32'h0);
		chk("unbalance", {{15{na[16]}}, na}, q);
		step(brk_v(rm()), 1'b0, 3'b000);
		av(1'b0, 8'h08, 32'h0);
		chk("diff", 32'h0, q);
		av(1'b0, 8'h0C, 32'h0);
		na = {sa[15], sa} - {ra[15], ra} - na;
		chk("angle", {{15{na[16]}}, na}, q);
		av(1'b1, 8'h00, 32'hC);
		av(1'b1, 8'h00, 32'h1C);
		av(1'b1, 8'h00, 32'hC);
		step(brk_v(rm()), 1'b0, 3'b000);
		av(1'b1, 8'h00, 32'h6);
		step(brk_v(rm()), 1'b0, 3'b100);
		$display("test residual done");
		av(1'b1, 8'h00, 32'h1);
		step(brk_v(rm()), 1'b0, 3'b100);
		repeat (2) step(brk_v(rm()), 1'b0, 3'b100);
		step(brk_v(rm()), 1'b0, 3'b101);
		@(posedge clk_in);
		gen_reset_in <= 1'b1;
		@(posedge clk_in);
		gen_reset_in <= 1'b0;
		@(negedge clk_in);
		chk("flags", 32'h0, {29'h0, st, bl, al});
		step(brk_v(rm()), 1'b0, 3'b100);
		$display("test group switch and general reset done");
		end_sim();
	end
endmodule // ctsup_top_bench

`default_nettype wire
